// ==== core/floppy_if_strap_config_map.vh ====
// Constants for the floppy interface strap configuration logic
`ifndef FLOPPY_IF_STRAP_CONFIG_MAP_VH
`define FLOPPY_IF_STRAP_CONFIG_MAP_VH
`define IRQ_LINES 7
`define IRQ_IDX_F 5
`define IRQ_IDX_G 6
`define LATE_ISSUE_MIN 4'h4
`define STRAP_SETTLE_NS 1000
`define CLK_PERIOD_NS 100
`define STRAP_SETTLE_CYC ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STATE_IDLE 2'h0
`define STATE_HOLD 2'h1
`define STATE_OWN 2'h2
`endif

// ==== core/floppy_if_strap_config.v ====
// Strap-selected drive, DMA chain and interrupt routing logic
//
`timescale 1ns/1ps
`include "floppy_if_strap_config_map.vh"

// What this block does
// - Each module has its own DMA engine; grant chain position fixes priority.
// - Nearest module wins; grant passes on only when this module is idle.
// - Family link picks standard or mini drives; daisy link shares mini lines.
// - Without daisy link, drive 0 and drive 1 ready inputs stay separate.
// - Ready link forces ready active or follows the drive state.
// - Select-gating link absent: drive selects only active with head load.
// - Subchannel links fitted: shared pin accepts the other module's DMA request.
// - Otherwise shared pin flags multiple addressing; never in subchannel mode.
// - Controller interrupt goes to at most one of seven lines; one link only.
// - In subchannel mode lines six and seven carry read and write strobes.
// - Issue three or lower, non-dual-height: a routing link must be fitted.
// - Hold request to host; bus driven only after hold acknowledge.
module floppy_if_strap_config (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Link straps
	input wire link_standard,
	input wire link_daisy,
	input wire link_ready_forced,
	input wire link_sel_free,
	input wire link_subchannel,
	input wire [6:0] irq_route_links,
	input wire [3:0] hw_issue,
	input wire dual_height,
	// Controller side
	input wire ctl_irq,
	input wire ctl_dma_req,
	input wire ctl_sel0,
	input wire ctl_sel1,
	input wire ctl_head_load,
	input wire sub_rd_strobe,
	input wire sub_wr_strobe,
	input wire addr_multi_hit,
	// Host bus DMA chain
	output reg hold_req,
	input wire hold_ack,
	input wire chained_grant_in,
	output reg chained_grant_out,
	output reg host_bus_release,
	output reg dma_granted,
	// Shared pin (four signals)
	input wire shared_pin_in,
	output reg multi_address_flag,
	output reg shared_pin_oe,
	output reg sub_dma_req,
	// Interrupt lines, index 0 is irq_line_a
	output reg [6:0] irq_line_out,
	output reg [6:0] irq_line_oe,
	// Drive side
	input wire ready0_in,
	input wire ready1_in,
	output reg drive_sel0,
	output reg drive_sel1,
	output reg drive_ready0,
	output reg drive_ready1,
	output reg mini_drive,
	output reg daisy_mode,
	// Configuration status
	output reg config_valid,
	output reg config_error
);

reg [3:0] settle_cnt;
reg captured;
reg cap_standard, cap_daisy, cap_ready_forced, cap_sel_free, cap_sub;
reg [6:0] cap_route;
reg cap_route_err;
reg [1:0] state;
reg [1:0] next_state;
reg hack_s1, hack_s2, gin_s1, gin_s2, pin_s1, pin_s2, r0_s1, r0_s2, r1_s1, r1_s2;
reg [6:0] next_irq_out;
reg [6:0] next_irq_oe;
reg [2:0] route_count;
reg [6:0] sub_mask;
reg dma_active;
integer i;
// Strap synchronisers; links are pins even though they are static
reg std_s1;
reg std_s2;
reg daisy_s1;
reg daisy_s2;
reg rdyf_s1;
reg rdyf_s2;
reg self_s1;
reg self_s2;
reg sub_s1;
reg sub_s2;
reg dual_s1;
reg dual_s2;
reg [6:0] route_s1;
reg [6:0] route_s2;
reg [3:0] issue_s1;
reg [3:0] issue_s2;

// Two flops per strap; a link touched during power-up must not go metastable
// The settle count covers both stages, so no capture latency is added
always @(posedge clk_sys) begin
	if (!rst_n) begin
		std_s1 <= 1'b0;
		std_s2 <= 1'b0;
		daisy_s1 <= 1'b0;
		daisy_s2 <= 1'b0;
		rdyf_s1 <= 1'b0;
		rdyf_s2 <= 1'b0;
		self_s1 <= 1'b0;
		self_s2 <= 1'b0;
		sub_s1 <= 1'b0;
		sub_s2 <= 1'b0;
		dual_s1 <= 1'b0;
		dual_s2 <= 1'b0;
		route_s1 <= 7'h00;
		route_s2 <= 7'h00;
		issue_s1 <= 4'h0;
		issue_s2 <= 4'h0;
	end else begin
		std_s1 <= link_standard;
		std_s2 <= std_s1;
		daisy_s1 <= link_daisy;
		daisy_s2 <= daisy_s1;
		rdyf_s1 <= link_ready_forced;
		rdyf_s2 <= rdyf_s1;
		self_s1 <= link_sel_free;
		self_s2 <= self_s1;
		sub_s1 <= link_subchannel;
		sub_s2 <= sub_s1;
		dual_s1 <= dual_height;
		dual_s2 <= dual_s1;
		route_s1 <= irq_route_links;
		route_s2 <= route_s1;
		issue_s1 <= hw_issue;
		issue_s2 <= issue_s1;
	end
end

// Two-flop synchronisers on all pin inputs
always @(posedge clk_sys) begin
	if (!rst_n) begin
		hack_s1 <= 1'b0;
		hack_s2 <= 1'b0;
		gin_s1 <= 1'b0;
		gin_s2 <= 1'b0;
		pin_s1 <= 1'b0;
		pin_s2 <= 1'b0;
		r0_s1 <= 1'b0;
		r0_s2 <= 1'b0;
		r1_s1 <= 1'b0;
		r1_s2 <= 1'b0;
	end else begin
		hack_s1 <= hold_ack;
		hack_s2 <= hack_s1;
		gin_s1 <= chained_grant_in;
		gin_s2 <= gin_s1;
		pin_s1 <= shared_pin_in;
		pin_s2 <= pin_s1;
		r0_s1 <= ready0_in;
		r0_s2 <= r0_s1;
		r1_s1 <= ready1_in;
		r1_s2 <= r1_s1;
	end
end

// Count of fitted routing links
always @* begin
	route_count = 3'h0;
	for (i = 0; i < `IRQ_LINES; i = i + 1) begin
		route_count = route_count + {2'h0, route_s2[i]};
	end
end

// Straps sampled once after settling; later changes are ignored
always @(posedge clk_sys) begin
	if (!rst_n) begin
		settle_cnt <= 4'h0;
		captured <= 1'b0;
		cap_standard <= 1'b0;
		cap_daisy <= 1'b0;
		cap_ready_forced <= 1'b0;
		cap_sel_free <= 1'b0;
		cap_sub <= 1'b0;
		cap_route <= 7'h00;
		cap_route_err <= 1'b0;
	end else if (!captured) begin
		if (settle_cnt == `STRAP_SETTLE_CYC - 1) begin
			captured <= 1'b1;
			cap_standard <= std_s2;
			cap_daisy <= daisy_s2;
			cap_ready_forced <= rdyf_s2;
			cap_sel_free <= self_s2;
			cap_sub <= sub_s2;
			cap_route <= route_s2;
			cap_route_err <= (route_count > 3'h1) ||
				(sub_s2 && (route_s2[`IRQ_IDX_F] ||
				route_s2[`IRQ_IDX_G])) ||
				(route_count == 3'h0 && !dual_s2 &&
				issue_s2 < `LATE_ISSUE_MIN);
		end else begin
			settle_cnt <= settle_cnt + 4'h1;
		end
	end
end

// Subchannel mode takes the two top lines away from routing
always @* begin
	sub_mask = 7'h00;
	if (cap_sub) begin
		sub_mask[`IRQ_IDX_F] = 1'b1;
		sub_mask[`IRQ_IDX_G] = 1'b1;
	end
	next_irq_out = 7'h00;
	next_irq_oe = 7'h00;
	if (captured && !cap_route_err) begin
		next_irq_oe = cap_route & ~sub_mask;
		next_irq_out = next_irq_oe & {7{ctl_irq}};
	end
	if (cap_sub && captured) begin
		next_irq_oe = next_irq_oe | sub_mask;
		next_irq_out[`IRQ_IDX_F] = sub_rd_strobe;
		next_irq_out[`IRQ_IDX_G] = sub_wr_strobe;
	end
end

// Requests from this controller or the served subchannel
always @* begin
	dma_active = captured && (ctl_dma_req || (cap_sub && pin_s2));
end

// Chain arbiter
always @* begin
	next_state = state;
	case (state)
	`STATE_IDLE: begin
		if (dma_active)
			next_state = `STATE_HOLD;
	end
	`STATE_HOLD: begin
		if (!dma_active)
			next_state = `STATE_IDLE;
		else if (hack_s2 && gin_s2)
			next_state = `STATE_OWN;
	end
	`STATE_OWN: begin
		if (!dma_active || !hack_s2)
			next_state = `STATE_IDLE;
	end
	default: next_state = `STATE_IDLE;
	endcase
end

always @(posedge clk_sys) begin
	if (!rst_n) begin
		state <= `STATE_IDLE;
		hold_req <= 1'b0;
		chained_grant_out <= 1'b0;
		host_bus_release <= 1'b0;
		dma_granted <= 1'b0;
		multi_address_flag <= 1'b0;
		shared_pin_oe <= 1'b0;
		sub_dma_req <= 1'b0;
		irq_line_out <= 7'h00;
		irq_line_oe <= 7'h00;
		drive_sel0 <= 1'b0;
		drive_sel1 <= 1'b0;
		drive_ready0 <= 1'b0;
		drive_ready1 <= 1'b0;
		mini_drive <= 1'b0;
		daisy_mode <= 1'b0;
		config_valid <= 1'b0;
		config_error <= 1'b0;
	end else begin
		state <= next_state;
		hold_req <= (next_state != `STATE_IDLE);
		// Grant passes down only while this module does not want the bus
		chained_grant_out <= gin_s2 && !dma_active && state == `STATE_IDLE;
		host_bus_release <= (next_state == `STATE_OWN);
		dma_granted <= (next_state == `STATE_OWN);
		// Flag output is refused in subchannel mode to avoid a pin fight
		shared_pin_oe <= captured && !cap_sub;
		multi_address_flag <= captured && !cap_sub && addr_multi_hit;
		sub_dma_req <= captured && cap_sub && pin_s2;
		irq_line_out <= next_irq_out;
		irq_line_oe <= next_irq_oe;
		mini_drive <= captured && !cap_standard;
		daisy_mode <= captured && !cap_standard && cap_daisy;
		drive_sel0 <= ctl_sel0 && (cap_sel_free || ctl_head_load);
		drive_sel1 <= ctl_sel1 && (cap_sel_free || ctl_head_load);
		if (cap_ready_forced) begin
			drive_ready0 <= 1'b1;
			drive_ready1 <= 1'b1;
		end else if (cap_daisy && !cap_standard) begin
			drive_ready0 <= r0_s2 && ctl_sel0;
			drive_ready1 <= r0_s2 && ctl_sel1;
		end else begin
			drive_ready0 <= r0_s2;
			drive_ready1 <= r1_s2;
		end
		config_valid <= captured && !cap_route_err;
		config_error <= captured && cap_route_err;
	end
end

endmodule // floppy_if_strap_config

// ==== dv/floppy_if_strap_config_chk.sv ====
// Port assertions for the strap configuration block
`timescale 1ns/1ps
module floppy_if_strap_config_chk(
	input wire logic clk_sys, rst_n, link_sel_free, link_subchannel, ctl_dma_req,
	input wire logic ctl_head_load, hold_req, hold_ack, chained_grant_in, chained_grant_out,
	input wire logic host_bus_release, dma_granted, shared_pin_oe, drive_sel0, drive_sel1,
	input wire logic config_valid, config_error,
	input wire logic [6:0] irq_line_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_grant_same: assert property (dma_granted == host_bus_release)
		else $error("grant flags differ");
	chk_sel_gated: assert property (!link_sel_free && !$past(ctl_head_load)
		|-> !drive_sel0 && !drive_sel1) else $error("select without head load");
	chk_grant_held: assert property (ctl_dma_req |=> !chained_grant_out)
		else $error("grant passed while busy");
	chk_grant_pass: assert property ((!ctl_dma_req && !hold_req && chained_grant_in)[*4]
		|-> chained_grant_out) else $error("grant not passed");
	chk_hold_rise: assert property (config_valid && $rose(ctl_dma_req)
		|-> ##[1:3] hold_req) else $error("no hold request");
	chk_bus_owned: assert property ((ctl_dma_req && hold_ack && chained_grant_in)[*4]
		|-> host_bus_release) else $error("bus not taken");
	chk_mute_error: assert property (config_error && !link_subchannel
		|-> irq_line_oe == 7'h00) else $error("routed despite error");
	chk_sub_pins: assert property (config_valid && link_subchannel
		|-> irq_line_oe[6:5] == 2'h3 && !shared_pin_oe) else $error("subchannel pins wrong");
	cover property (host_bus_release);
	cover property (config_error);
	cover property (chained_grant_out);
endmodule // floppy_if_strap_config_chk
bind floppy_if_strap_config floppy_if_strap_config_chk chk_i(.*);

// ==== dv/host_bus_model.sv ====
// Host bus and neighbour modules on the DMA grant chain
`timescale 1ns/1ps
module host_bus_model(
	input wire logic clk_sys, hold_req, up_req, down_req, slow,
	output logic hold_ack,
	output logic chained_grant_in
);
	logic [3:0] req_pipe = 4'h0;
	initial hold_ack = 1'b0;
	always @(posedge clk_sys) begin
		req_pipe <= {req_pipe[2:0], hold_req | up_req | down_req};
		hold_ack <= slow ? req_pipe[3] : req_pipe[0];
	end
	// Nearer module keeps the grant while it wants the bus
	assign chained_grant_in = hold_ack & ~up_req;
endmodule // host_bus_model

// ==== dv/floppy_if_strap_config_tb.sv ====
// Self-checking bench for the strap configuration block
`timescale 1ns/1ps
module floppy_if_strap_config_tb;
	logic clk_sys = 0, rst_n = 0, up_req = 0, down_req = 0, slow = 0;
	logic link_standard, link_daisy, link_ready_forced, link_sel_free, link_subchannel;
	logic dual_height, ctl_irq, ctl_dma_req, ctl_sel0, ctl_sel1, ctl_head_load, sub_rd_strobe;
	logic sub_wr_strobe, addr_multi_hit, hold_req, hold_ack, chained_grant_in, chained_grant_out;
	logic host_bus_release, dma_granted, shared_pin_in, multi_address_flag, shared_pin_oe;
	logic sub_dma_req, ready0_in, ready1_in, drive_sel0, drive_sel1, drive_ready0, drive_ready1;
	logic mini_drive, daisy_mode, config_valid, config_error;
	logic [6:0] irq_route_links, irq_line_out, irq_line_oe;
	logic [3:0] hw_issue;
	int fail_count = 0, check_count = 0;
	floppy_if_strap_config dut(.*);
	host_bus_model host(.*);
	always #50 clk_sys = ~clk_sys;
	task chk(input logic [7:0] s, e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("Error %0t: got %h exp %h", $time, s, e);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Straps change only under reset, since they are captured once
	task cfg(input logic [6:0] irq, logic [3:0] iss, logic [5:0] s, logic [7:0] e);
		rst_n <= 0;
		irq_route_links <= irq;
		hw_issue <= iss;
		{dual_height, link_standard, link_daisy, link_ready_forced, link_sel_free,
			link_subchannel} <= s;
		w(6);
		rst_n <= 1;
		w(14);
		chk({config_error, irq_line_oe}, e);
	endtask
	task wait_rel;
		for (int n = 0; n < 30 && host_bus_release !== 1; n++)
			w(1);
		chk(host_bus_release, 1);
	endtask
	task finish_test;
		$display("Checks %0d, errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Run needs about 330 cycles
	initial begin
		repeat (3000) @(posedge clk_sys);
		fail_count++;
		finish_test;
	end
	initial begin
		{ctl_dma_req, ctl_sel0, ctl_sel1, ctl_head_load, sub_rd_strobe, sub_wr_strobe} = 0;
		{addr_multi_hit, shared_pin_in, ready0_in, ready1_in} = 0;
		ctl_irq = 1;
		for (int i = 0; i < 7; i++) begin
			cfg(7'h01 << i, 4'h4, 6'h00, 8'h01 << i);
			chk(irq_line_out, 7'h01 << i);
			chk(config_valid, 1);
		end
		cfg(7'h03, 4'h4, 6'h00, 8'h80);
		cfg(7'h00, 4'h3, 6'h00, 8'h80);
		cfg(7'h00, 4'h3, 6'h20, 8'h00);
		cfg(7'h40, 4'h4, 6'h01, 8'he0);
		cfg(7'h01, 4'h4, 6'h01, 8'h61);
		shared_pin_in <= 1;
		sub_rd_strobe <= 1;
		w(4);
		chk({sub_dma_req, shared_pin_oe, irq_line_out[6:5]}, 8'h09);
		cfg(7'h01, 4'h4, 6'h10, 8'h01);
		{addr_multi_hit, ready1_in, ctl_sel0} <= 3'h7;
		w(4);
		chk({mini_drive, drive_ready1, drive_ready0, drive_sel0, shared_pin_oe,
			multi_address_flag}, 8'h13);
		{ctl_head_load, ctl_sel1} <= 2'h3;
		w(2);
		chk({drive_sel1, drive_sel0}, 8'h03);
		ctl_head_load <= 0;
		cfg(7'h01, 4'h4, 6'h0e, 8'h01);
		w(4);
		chk({mini_drive, daisy_mode, drive_ready0, drive_sel0}, 8'h0f);
		ctl_dma_req <= 1;
		wait_rel;
		chk({dma_granted, chained_grant_out}, 8'h02);
		ctl_dma_req <= 0;
		w(8);
		chk(hold_req, 0);
		slow <= 1;
		up_req <= 1;
		ctl_dma_req <= 1;
		w(12);
		chk(host_bus_release, 0);
		up_req <= 0;
		wait_rel;
		ctl_dma_req <= 0;
		down_req <= 1;
		w(10);
		chk(chained_grant_out, 1);
		finish_test;
	end
endmodule // floppy_if_strap_config_tb
